// ---- inc/fmrc_pkg.sv ----
// constants, types and layouts for the alert mask / readback config block
package fmrc_pkg;

  // widths
  localparam int REG_W   = 22;
  localparam int FRAME_W = 24;
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 5;
  localparam int HWA_W   = 2;
  localparam int MODE_W  = 2;
  localparam int CNT_W   = 5;
  localparam int FLT_W   = 10;
  localparam int SEL_W   = 7;

  // register field positions
  localparam int ALERT_BIT = 21;
  localparam int ADDR_LSB  = 16;
  localparam int MODE_LSB  = 5;
  localparam int SEL_LSB   = 0;

  // alert mask bit positions
  localparam int MB_INVALID = 15;
  localparam int MB_INVCODE = 12;
  localparam int MB_OSC     = 10;
  localparam int MB_LATCH   = 9;
  localparam int MB_WDOG    = 8;
  localparam int MB_SLIP    = 7;
  localparam int MB_CRC     = 5;
  localparam int MB_OPEN    = 3;
  localparam int MB_SHORT   = 2;
  localparam int MB_TEMP    = 0;

  // reset values for the registers and the outgoing word
  localparam logic [REG_W-1:0]   ALERT_MASK_RST = 22'h120000;
  localparam logic [REG_W-1:0]   RB_CFG_RST     = 22'h130000;
  localparam logic [SEL_W-1:0]   RB_SEL_RST     = 7'h00;
  localparam logic [DATA_W-1:0]  MASK_RST       = 16'h0000;
  localparam logic [FRAME_W-1:0] TX_RST         = 24'h200000;

  // serial frame bit counts
  localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
  localparam logic [CNT_W-1:0] CNT_SAT  = 5'h1F;
  localparam logic [CNT_W-1:0] TOP_BIT  = 5'h17;

  // readback target codes
  typedef enum logic [ADDR_W-1:0] {
    RB_NO_OPERATION_REGISTER  = 5'h00,
    RB_OUT_INPUT              = 5'h01,
    RB_OUT_LEVEL              = 5'h02,
    RB_CLEAR_CODE             = 5'h03,
    RB_GAIN                   = 5'h04,
    RB_OFFSET                 = 5'h05,
    RB_OUT_CONFIG             = 5'h06,
    RB_SOFTWARE_LOAD_REGISTER = 5'h07,
    RB_KEY                    = 5'h08,
    RB_ALERT_MASK             = 5'h12,
    RB_READBACK_CONFIG        = 5'h13,
    RB_STATUS                 = 5'h16
  } fmrc_target_t;

  // readback modes
  typedef enum logic [MODE_W-1:0] {
    MODE_TWO_STAGE = 2'h0,
    MODE_AUTO      = 2'h1,
    MODE_SHARED    = 2'h2,
    MODE_ALTERNATE = 2'h3
  } fmrc_mode_t;

  // fault flags from the rest of the chip
  typedef struct packed {
    logic invalid_access_flag;
    logic inverse_code_check_flag;
    logic osc_halt_flag;
    logic output_latch_monitor_flag;
    logic watchdog_timeout_flag;
    logic frame_slip_flag;
    logic checksum_flag;
    logic current_open_circuit_flag;
    logic voltage_short_flag;
    logic die_overtemp_flag;
  } fmrc_fault_t;

  // one serial frame, first bit in the top position
  typedef struct packed {
    logic [HWA_W-1:0]  hw_addr;
    logic              spare;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] data;
  } fmrc_frame_t;

endpackage : fmrc_pkg

// ---- verilog/fmrc_regs.sv ----
// alert mask and readback configuration registers behind the serial port
`timescale 1ns/1ns

// Operation
// RULE_01: readback carries live alert level in bit 21, own address in 20:16.
// RULE_02: readback config resets to 0x130000, alert mask to its own address.
// RULE_03: mask bits exclude faults from the alert pin; all reset to zero.
// RULE_04: mask bit 15 blocks the invalid serial access flag.
// RULE_05: mask bit 12 blocks the inverse output code check flag.
// RULE_06: mask bit 10 blocks the oscillator stop detection flag.
// RULE_07: mask bit 9 blocks the output latch monitor flag.
// RULE_08: mask bit 8 blocks the watchdog timeout flag, kept clear of bit 3.
// RULE_09: mask bit 7 blocks the frame slip flag.
// RULE_10: mask bit 5 blocks the serial checksum flag.
// RULE_11: mask bit 3 blocks the current output open circuit flag.
// RULE_12: mask bit 2 blocks the voltage output short circuit flag.
// RULE_13: mask bit 0 blocks the die overtemperature flag.
// RULE_14: bits 4:0 of readback config hold the two-stage readback target.
// RULE_15: target codes 0x00 to 0x08 select the listed registers in order.
// RULE_16: mode field bits 6:5 resets to 00, two-stage readback.
// RULE_17: mode 01 shifts status out on every serial frame.
// RULE_18: mode 10 sets an internal flag after each valid write to it.
// RULE_19: mode 10 drives status out only when the previous write was valid.
// RULE_20: host addresses devices on a shared select line by hardware address.
// RULE_21: mode 11 alternates status and the previous frame's instruction.
// RULE_22: code 0x16 selects status, code 0x12 selects the alert mask.
// RULE_23: alert pin low while any unmasked fault flag is set.
// RULE_24: readback config bits 15:7 read zero and ignore writes.
module fmrc_regs #(
  parameter int SYNC_STAGES = 2
) (
  // system clock and reset
  input  wire logic                                clock_in,
  input  wire logic                                rst_n_in,
  // serial link pins
  input  wire logic                                sclk_in,
  input  wire logic                                sync_n_in,
  input  wire logic                                sdi_in,
  output logic                                     sdo_out,
  output logic                                     sdo_en_out,
  input  wire logic [fmrc_pkg::HWA_W-1:0]          hw_addr_in,
  // chip side
  input  wire fmrc_pkg::fmrc_fault_t               faults_in,
  input  wire logic [fmrc_pkg::DATA_W-1:0]         status_in,
  output logic                                     alert_n_out,
  output logic [fmrc_pkg::ADDR_W-1:0]              rb_select_out,
  output logic [fmrc_pkg::MODE_W-1:0]              rb_mode_out
);

  localparam int RAW_W = 1 + fmrc_pkg::HWA_W + fmrc_pkg::FLT_W;

  // parameter check
  generate
    if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
    end
  endgenerate

  // fault flags that reach the pin when not masked
  function automatic logic [fmrc_pkg::FLT_W-1:0] fault_hits(
    input fmrc_pkg::fmrc_fault_t f,
    input logic [fmrc_pkg::DATA_W-1:0] m
  );
    fault_hits = {
      f.invalid_access_flag       & ~m[fmrc_pkg::MB_INVALID], // RULE_04
      f.inverse_code_check_flag   & ~m[fmrc_pkg::MB_INVCODE], // RULE_05
      f.osc_halt_flag             & ~m[fmrc_pkg::MB_OSC],     // RULE_06
      f.output_latch_monitor_flag & ~m[fmrc_pkg::MB_LATCH],   // RULE_07
      f.watchdog_timeout_flag     & ~m[fmrc_pkg::MB_WDOG],    // RULE_08
      f.frame_slip_flag           & ~m[fmrc_pkg::MB_SLIP],    // RULE_09
      f.checksum_flag             & ~m[fmrc_pkg::MB_CRC],     // RULE_10
      f.current_open_circuit_flag & ~m[fmrc_pkg::MB_OPEN],    // RULE_11
      f.voltage_short_flag        & ~m[fmrc_pkg::MB_SHORT],   // RULE_12
      f.die_overtemp_flag         & ~m[fmrc_pkg::MB_TEMP]     // RULE_13
    };
  endfunction : fault_hits

  // one 22-bit readback word for a target code
  function automatic logic [fmrc_pkg::REG_W-1:0] rd_word(
    input logic [fmrc_pkg::ADDR_W-1:0] code,
    input logic                        alert,
    input logic [fmrc_pkg::DATA_W-1:0] mask,
    input logic [fmrc_pkg::SEL_W-1:0]  rbcfg,
    input logic [fmrc_pkg::DATA_W-1:0] status
  );
    logic [fmrc_pkg::DATA_W-1:0] body;
    body = '0;
    case (code)
      fmrc_pkg::RB_ALERT_MASK:      body = mask;            // RULE_22
      fmrc_pkg::RB_READBACK_CONFIG: body = {9'h000, rbcfg}; // RULE_24
      fmrc_pkg::RB_STATUS:          body = status;          // RULE_22
      default:                      body = '0;
    endcase
    rd_word = {alert, code, body}; // RULE_01
  endfunction : rd_word

  // ---------------------------------------------------------------
  // link domain: runs on the host's serial clock
  // ---------------------------------------------------------------
  logic                               armed_reg;
  logic [fmrc_pkg::CNT_W-1:0]         rx_cnt_reg;
  logic [fmrc_pkg::FRAME_W-1:0]       rx_shift_reg;
  logic [fmrc_pkg::CNT_W-1:0]         tx_idx;
  logic [fmrc_pkg::CNT_W-1:0]         tx_pos;
  logic [fmrc_pkg::FRAME_W-1:0]       tx_word_reg;
  logic                               tx_en_reg;

  // limitation: the armed flag has no reset, so the host must raise select
  // once before its first frame; a missed edge would garble that frame
  // armed while select is high; the first clock edge of a frame restarts
  // the count, so nothing depends on edges before the frame starts
  always_ff @(posedge sclk_in or posedge sync_n_in) begin
    if (sync_n_in) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // shift in on rising edges; count saturates to flag long frames
  always_ff @(posedge sclk_in) begin
    rx_shift_reg <= {rx_shift_reg[fmrc_pkg::FRAME_W-2:0], sdi_in};
    if (armed_reg) begin
      rx_cnt_reg <= fmrc_pkg::CNT_ONE;
    end else if (rx_cnt_reg != fmrc_pkg::CNT_SAT) begin
      rx_cnt_reg <= rx_cnt_reg + fmrc_pkg::CNT_ONE;
    end
  end

  // outgoing bit: tx word is frozen while select is low
  assign tx_idx  = armed_reg ? '0 : rx_cnt_reg;
  assign tx_pos  = fmrc_pkg::TOP_BIT - tx_idx;
  assign sdo_en_out = ~sync_n_in & tx_en_reg;
  assign sdo_out = sdo_en_out && (tx_idx < fmrc_pkg::CNT_FULL) ?
                   tx_word_reg[tx_pos] : 1'b0;

  // ---------------------------------------------------------------
  // system domain
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } fmrc_state_t;

  fmrc_state_t                        state_reg;
  fmrc_state_t                        state_next;
  logic [RAW_W-1:0]                   sync_pipe_reg [SYNC_STAGES];
  logic [RAW_W-1:0]                   raw_pins;
  logic                               sync_n_s;
  logic [fmrc_pkg::HWA_W-1:0]         hw_addr_s;
  fmrc_pkg::fmrc_fault_t              faults_s;
  logic [fmrc_pkg::DATA_W-1:0]        mask_reg;
  logic [fmrc_pkg::DATA_W-1:0]        mask_next;
  logic [fmrc_pkg::SEL_W-1:0]         rb_reg;
  logic [fmrc_pkg::SEL_W-1:0]         rb_next;
  logic                               valid_flag_reg;
  logic                               valid_flag_next;
  logic                               alt_reg;
  logic                               alert_n_reg;
  logic [fmrc_pkg::FRAME_W-1:0]       tx_word_next;
  logic                               tx_en_next;

  // select, hardware address and fault pins pass a synchroniser chain before use; status_in is used directly
  assign raw_pins = {sync_n_in, hw_addr_in, faults_in};
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_pipe_reg[i] <= {1'b1, {(RAW_W-1){1'b0}}};
      end
    end else begin
      sync_pipe_reg[0] <= raw_pins;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_pipe_reg[i] <= sync_pipe_reg[i-1];
      end
    end
  end
  assign {sync_n_s, hw_addr_s, faults_s} = sync_pipe_reg[SYNC_STAGES-1];

  // frame decode; shift and count are static while select is high
  fmrc_pkg::fmrc_frame_t              rx_frame;
  logic                               frame_end;
  logic                               frame_ok;
  logic                               wr_mask;
  logic                               wr_rb;
  fmrc_pkg::fmrc_mode_t               mode_next;
  logic [fmrc_pkg::ADDR_W-1:0]        sel_next;
  logic [fmrc_pkg::REG_W-1:0]         status_word;
  logic [fmrc_pkg::REG_W-1:0]         select_word;

  assign rx_frame  = fmrc_pkg::fmrc_frame_t'(rx_shift_reg);
  assign frame_end = (state_reg == ST_BUSY) && sync_n_s;
  assign frame_ok  = frame_end && (rx_cnt_reg == fmrc_pkg::CNT_FULL) &&
                     (rx_frame.hw_addr == hw_addr_s); // RULE_20
  assign wr_mask   = frame_ok &&
                     (rx_frame.reg_addr == fmrc_pkg::RB_ALERT_MASK);
  assign wr_rb     = frame_ok &&
                     (rx_frame.reg_addr == fmrc_pkg::RB_READBACK_CONFIG);

  // select-line tracker
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (!sync_n_s) state_next = ST_BUSY;
      ST_BUSY: if (sync_n_s) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // register writes; only the low seven config bits are stored
  assign mask_next = wr_mask ? rx_frame.data : mask_reg; // RULE_03
  assign rb_next   = wr_rb ? rx_frame.data[fmrc_pkg::SEL_W-1:0]
                           : rb_reg; // RULE_24
  assign mode_next = fmrc_pkg::fmrc_mode_t'(
                       rb_next[fmrc_pkg::MODE_LSB +: fmrc_pkg::MODE_W]);
  assign sel_next  = rb_next[fmrc_pkg::SEL_LSB +: fmrc_pkg::ADDR_W]; // RULE_14

  // valid-write flag: a valid write sets it, any other frame clears it
  assign valid_flag_next = frame_ok ? 1'b1 :
                           (frame_end ? 1'b0 : valid_flag_reg); // RULE_18

  // answer for the next frame, built when this one ends
  assign status_word = rd_word(fmrc_pkg::RB_STATUS, alert_n_reg,
                               mask_next, rb_next, status_in);
  assign select_word = rd_word(sel_next, alert_n_reg,
                               mask_next, rb_next, status_in); // RULE_15

  always_comb begin
    tx_word_next = {2'b00, select_word};
    tx_en_next   = 1'b1;
    case (mode_next)
      fmrc_pkg::MODE_TWO_STAGE: tx_word_next = {2'b00, select_word}; // RULE_16
      fmrc_pkg::MODE_AUTO:      tx_word_next = {2'b00, status_word}; // RULE_17
      fmrc_pkg::MODE_SHARED: begin
        tx_word_next = {2'b00, status_word};
        tx_en_next   = valid_flag_next; // RULE_19
      end
      fmrc_pkg::MODE_ALTERNATE: begin
        tx_word_next = alt_reg ? rx_shift_reg
                               : {2'b00, status_word}; // RULE_21
      end
      default: tx_word_next = {2'b00, select_word};
    endcase
  end

  // state and configuration registers
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_reg      <= ST_IDLE;
      mask_reg       <= fmrc_pkg::MASK_RST; // RULE_02
      rb_reg         <= fmrc_pkg::RB_SEL_RST; // RULE_02
      valid_flag_reg <= 1'b0;
      alt_reg        <= 1'b0;
    end else begin
      state_reg      <= state_next;
      mask_reg       <= mask_next;
      rb_reg         <= rb_next;
      valid_flag_reg <= valid_flag_next;
      alt_reg        <= frame_end ? ~alt_reg : alt_reg; // RULE_21
    end
  end

  // outgoing word updates only between frames, never mid-shift
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_word_reg <= fmrc_pkg::TX_RST;
      tx_en_reg   <= 1'b1;
    end else if (frame_end) begin
      tx_word_reg <= tx_word_next;
      tx_en_reg   <= tx_en_next;
    end
  end

  // alert pin is registered so it never glitches on flag skew
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      alert_n_reg <= 1'b1;
    end else begin
      alert_n_reg <= ~|fault_hits(faults_s, mask_reg); // RULE_23
    end
  end

  assign alert_n_out   = alert_n_reg;
  assign rb_select_out = rb_reg[fmrc_pkg::SEL_LSB +: fmrc_pkg::ADDR_W];
  assign rb_mode_out   = rb_reg[fmrc_pkg::MODE_LSB +: fmrc_pkg::MODE_W];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_reset_values: assert property ( // RULE_02
    $rose(rst_n_in) |-> mask_reg == fmrc_pkg::MASK_RST &&
      rb_reg == fmrc_pkg::RB_SEL_RST && tx_word_reg == fmrc_pkg::TX_RST)
    else $error("register reset values wrong");

  a_mask_write: assert property ( // RULE_03
    wr_mask |=> mask_reg == $past(rx_frame.data))
    else $error("alert mask write lost");

  a_invalid_blocked: assert property ( // RULE_04
    (faults_s == fmrc_pkg::fmrc_fault_t'(10'h200)) &&
      mask_reg[fmrc_pkg::MB_INVALID] && $stable(mask_reg) |=> alert_n_out)
    else $error("masked invalid access drove alert");

  a_wdog_blocked: assert property ( // RULE_08
    (faults_s == fmrc_pkg::fmrc_fault_t'(10'h020)) &&
      mask_reg[fmrc_pkg::MB_WDOG] && $stable(mask_reg) |=> alert_n_out)
    else $error("masked watchdog drove alert");

  a_crc_blocked: assert property ( // RULE_10
    (faults_s == fmrc_pkg::fmrc_fault_t'(10'h008)) &&
      mask_reg[fmrc_pkg::MB_CRC] && $stable(mask_reg) |=> alert_n_out)
    else $error("masked checksum drove alert");

  a_temp_unmasked: assert property ( // RULE_13
    faults_s.die_overtemp_flag && !mask_reg[fmrc_pkg::MB_TEMP]
      |=> !alert_n_out)
    else $error("unmasked overtemperature missed");

  a_alert_clear: assert property ( // RULE_23
    ~|fault_hits(faults_s, mask_reg) |=> alert_n_out)
    else $error("alert low with no unmasked fault");

  a_select_write: assert property ( // RULE_14
    wr_rb |=> rb_select_out == $past(rx_frame.data[4:0]) &&
      tx_word_reg[20:16] == rb_select_out || rb_mode_out != 2'h0)
    else $error("readback target not taken");

  a_auto_status: assert property ( // RULE_17
    frame_end && mode_next == fmrc_pkg::MODE_AUTO
      |=> tx_word_reg[20:16] == fmrc_pkg::RB_STATUS && tx_en_reg)
    else $error("auto mode did not return status");

  a_shared_flag: assert property ( // RULE_18
    frame_ok |=> valid_flag_reg ##1 valid_flag_reg || $past(frame_end))
    else $error("valid write flag not set");

  a_shared_quiet: assert property ( // RULE_19
    frame_end && !frame_ok && mode_next == fmrc_pkg::MODE_SHARED
      |=> !tx_en_reg && !sdo_en_out)
    else $error("shared mode spoke after bad write");

  a_alt_order: assert property ( // RULE_21
    frame_end && mode_next == fmrc_pkg::MODE_ALTERNATE && alt_reg
      |=> tx_word_reg == $past(rx_shift_reg))
    else $error("alternate mode lost previous instruction");

  a_alert_bit: assert property ( // RULE_01
    frame_end |=> tx_word_reg[fmrc_pkg::ALERT_BIT] == $past(alert_n_reg)
      || (rb_mode_out == 2'h3 && !alt_reg))
    else $error("readback alert bit wrong");

  a_mask_readback: assert property ( // RULE_22
    frame_end && mode_next == fmrc_pkg::MODE_TWO_STAGE &&
      sel_next == fmrc_pkg::RB_ALERT_MASK
      |=> tx_word_reg[fmrc_pkg::DATA_W-1:0] == mask_reg)
    else $error("alert mask readback wrong");

  a_cfg_reserved: assert property ( // RULE_24
    frame_end && mode_next == fmrc_pkg::MODE_TWO_STAGE &&
      sel_next == fmrc_pkg::RB_READBACK_CONFIG
      |=> tx_word_reg[fmrc_pkg::DATA_W-1:fmrc_pkg::SEL_W] == '0)
    else $error("reserved config bits not zero");

  a_shared_speak: assert property ( // RULE_19
    frame_ok && mode_next == fmrc_pkg::MODE_SHARED |=> tx_en_reg)
    else $error("shared mode muted after valid write");

  c_auto_frame:   cover property (frame_end &&
                    mode_next == fmrc_pkg::MODE_AUTO);
  c_mask_write:   cover property (wr_mask);
  c_shared_quiet: cover property (frame_end && !tx_en_next);
  c_alert_low:    cover property ($fell(alert_n_out));
  c_alt_echo:     cover property (frame_end && rb_mode_out == 2'h3 && alt_reg);

endmodule : fmrc_regs

// ---- bench/fmrc_host_model.sv ----
// serial host controller model for the frame select link
`timescale 1ns/1ns
module fmrc_host_model (
  // link pins toward the device
  output logic      sclk_out,
  output logic      sync_n_out,
  output logic      sdi_out,
  // answer from the device
  input  wire logic sdo_in,
  input  wire logic sdo_en_in
);
  // link clock stands low and select high between frames
  initial begin
    sclk_out   = 1'b0;
    sync_n_out = 1'b0;
    sdi_out    = 1'b0;
    // a clean rising select edge arms the link logic, which has no reset
    #1;
    sync_n_out = 1'b1;
  end

  // one 24-bit frame, msb first; answer bits caught just before each rise
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx,
                      output logic en);
    int k;
    #7;
    sync_n_out = 1'b0;
    #15;
    en = sdo_en_in;
    for (k = 23; k >= 0; k--) begin
      sdi_out = tx[k];
      #15;
      rx[k]    = sdo_in;
      sclk_out = 1'b1;
      #15;
      sclk_out = 1'b0;
    end
    #15;
    sync_n_out = 1'b1;
    // a released data line must not look like it still holds its bit
    sdi_out = ~sdi_out;
    // idle gap well above five system clocks so the frame is taken
    #800;
  endtask : xfer
endmodule : fmrc_host_model

// ---- bench/tb_top.sv ----
// self-checking bench for the alert mask and readback config block
`timescale 1ns/1ns
module tb_top;
  localparam logic [1:0] HW = 2'h2;
  logic                  clock_in;
  logic                  rst_n_in;
  logic                  sclk;
  logic                  sync_n;
  logic                  sdi;
  logic                  sdo;
  logic                  sdo_en;
  logic                  alert_n;
  logic [1:0]            hw_addr;
  fmrc_pkg::fmrc_fault_t faults;
  logic [15:0]           status;
  logic [4:0]            rb_sel;
  logic [1:0]            rb_mode;
  logic [23:0]           rx;
  logic [23:0]           w2;
  logic [23:0]           sw;
  logic                  en;
  logic                  ok;
  int                    bad_count;
  int                    checked;
  int                    cycles;
  int                    i;
  // mask position for each fault flag, lsb flag first
  int pos [10] = '{0, 2, 3, 5, 7, 8, 9, 10, 12, 15};

  fmrc_regs i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .sclk_in(sclk), .sync_n_in(sync_n), .sdi_in(sdi), .sdo_out(sdo),
    .sdo_en_out(sdo_en), .hw_addr_in(hw_addr), .faults_in(faults),
    .status_in(status), .alert_n_out(alert_n), .rb_select_out(rb_sel),
    .rb_mode_out(rb_mode));

  fmrc_host_model i_host (.sclk_out(sclk), .sync_n_out(sync_n),
    .sdi_out(sdi), .sdo_in(sdo), .sdo_en_in(sdo_en));

  // system clock, 100 ns period
  always #50 clock_in = ~clock_in;

  // hang guard: the run needs well under two thousand cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one frame to this device's hardware address
  task automatic frame(input logic [4:0] a, input logic [15:0] d);
    i_host.xfer({HW, 1'b0, a, d}, rx, en);
  endtask : frame

  task automatic settle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : settle

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    clock_in  = 1'b0;
    rst_n_in  = 1'b0;
    hw_addr   = HW;
    faults    = '0;
    status    = 16'hA5C3;
    bad_count = 0;
    checked   = 0;
    cycles    = 0;
    repeat (8) @(posedge clock_in);
    #1 rst_n_in = 1'b1;
    settle(4);
    // reset values, then reserved config bits written as ones
    chk({16'h0, rb_mode, rb_sel, alert_n}, 24'h1);
    frame(5'h13, 16'h0012);
    chk(rx, 24'h200000);
    frame(5'h13, 16'h0013);
    chk(rx, 24'h320000);
    frame(5'h13, 16'hFF93);
    chk(rx, 24'h330013);
    frame(5'h13, 16'h0000);
    chk(rx, 24'h330013);
    $display("test reset_values done");
    // each target code answers in the frame after it is chosen
    for (i = 1; i <= 9; i++) begin
      frame(5'h13, 16'(i));
      chk({19'h0, rb_sel}, 24'(i));
      chk(rx, {3'b001, 5'(i - 1), 16'h0});
    end
    frame(5'h13, 16'h0016);
    frame(5'h13, 16'h0016);
    chk(rx, 24'h36A5C3);
    $display("test target_codes done");
    // every flag reaches the pin until its own mask bit is set
    for (i = 0; i < 10; i++) begin
      @(posedge clock_in);
      #1 faults = fmrc_pkg::fmrc_fault_t'(10'h001 << i);
      settle(5);
      chk({23'h0, alert_n}, 24'h0);
      frame(5'h12, 16'h0001 << pos[i]);
      chk({23'h0, alert_n}, 24'h1);
    end
    frame(5'h12, 16'h0001);
    chk({23'h0, alert_n}, 24'h0);
    frame(5'h13, 16'h0012);
    frame(5'h13, 16'h0012);
    chk(rx, 24'h120001);
    @(posedge clock_in);
    #1 faults = '0;
    $display("test alert_mask done");
    // automatic status on every frame follows live status
    frame(5'h13, 16'h0020);
    chk({22'h0, rb_mode}, 24'h1);
    frame(5'h00, 16'h0000);
    chk(rx, 24'h36A5C3);
    @(posedge clock_in);
    #1 status = 16'h5A3C;
    // the answer word is built as the frame before ends, so one frame lags
    frame(5'h00, 16'h0000);
    frame(5'h00, 16'h0000);
    chk(rx, 24'h365A3C);
    $display("test auto_status done");
    // shared select: a foreign frame writes nothing and mutes the next
    frame(5'h13, 16'h0040);
    frame(5'h00, 16'h0000);
    i_host.xfer({~HW, 1'b0, 5'h13, 16'h0000}, rx, en);
    chk({23'h0, en}, 24'h1);
    chk(rx, 24'h365A3C);
    chk({22'h0, rb_mode}, 24'h2);
    frame(5'h00, 16'h0000);
    chk({23'h0, en}, 24'h0);
    chk(rx, 24'h0);
    frame(5'h00, 16'h0000);
    chk({23'h0, en}, 24'h1);
    $display("test shared_select done");
    // alternate: status and the echoed frame take turns
    frame(5'h13, 16'h0060);
    frame(5'h00, 16'h1111);
    frame(5'h00, 16'h2222);
    w2 = rx;
    frame(5'h00, 16'h3333);
    sw = 24'h365A3C;
    ok = (w2 === sw && rx === {HW, 6'h00, 16'h2222}) ||
         (w2 === {HW, 6'h00, 16'h1111} && rx === sw);
    chk({23'h0, ok}, 24'h1);
    $display("test alternate done");
    wrap_up();
  end
endmodule : tb_top
